/* File: bench/bsl_strap_board.sv */
/*
 Board side of the strap pins: weak pulls inside the device and an
 optional host output per pin.
 Assumes pull enables come from the block; host drive from the bench.
*/
`timescale 1ns/1ns
module bsl_strap_board (
	input  wire logic       core_clk,
	input  wire logic [4:0] pull_up_en,
	input  wire logic [4:0] pull_dn_en,
	input  wire logic [4:0] host_en,
	input  wire logic [4:0] host_val,
	output logic      [4:0] pins
);
	logic [4:0] float_r;

	// Floating pins without pull wander every cycle
	always_ff @(posedge core_clk) begin
		float_r <= pins;
	end

	// Host outputs win, then weak pulls, else floating
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			if (host_en[i]) begin
				pins[i] = host_val[i];
			end else if (pull_up_en[i]) begin
				pins[i] = 1'b1;
			end else if (pull_dn_en[i]) begin
				pins[i] = 1'b0;
			end else begin
				pins[i] = (float_r[i] === 1'b1) ? 1'b0 : 1'b1;
			end
		end
	end
endmodule

/* File: bench/bsl_top_bench.sv */
/*
 Self-checking bench of the strap latch: pin capture across system
 resets, decoded settings, override and APB error responses.
 Assumes the APB slave answers with pready, checked by a monitor.
*/
`timescale 1ns/1ns
module bsl_top_bench;
	logic        core_clk, rst_b, sys_rst_b, psel, penable, pwrite;
	logic [2:0]  reset_cause;
	logic [4:0]  pins, host_en, host_val, pad_func_en, pull_up_en, pull_dn_en;
	logic [4:0]  strap_value, v;
	logic        strap_valid, flash_supply_1v8, boot_download, boot_reserved;
	logic        uart0_log_en, sdio_sample_rising, sdio_output_rising;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic        pready, pslverr;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	int          errors, samples_checked, seed;

	bsl_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .sys_rst_b(sys_rst_b),
		.reset_cause(reset_cause), .strap_pin_in(pins), .pad_func_en(pad_func_en),
		.pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .strap_value(strap_value),
		.strap_valid(strap_valid), .flash_supply_1v8(flash_supply_1v8),
		.boot_download(boot_download), .boot_reserved(boot_reserved),
		.uart0_log_en(uart0_log_en), .sdio_sample_rising(sdio_sample_rising),
		.sdio_output_rising(sdio_output_rising), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	bsl_strap_board u_board (.core_clk(core_clk), .pull_up_en(pull_up_en),
		.pull_dn_en(pull_dn_en), .host_en(host_en), .host_val(host_val), .pins(pins));

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, ex, got);
		end
	endtask

	task automatic stop_test;
		if (errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One APB transfer; expected {check data, err, data} noted first
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] s, input logic [33:0] ex);
		exp_q.push_back(ex);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) begin
			@(posedge core_clk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	// Monitor: completed transfers against the oldest note
	always @(posedge core_clk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			e = exp_q.pop_front();
			chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
			if (e[33]) begin
				chk("prdata", e[31:0], prdata);
			end
		end
	end

	function automatic logic [31:0] status_of(input logic [4:0] s);
		return {25'h0, 1'b1, s[4], s[3], s[3], ~s[1] & s[2], ~s[1] & ~s[2], s[0]};
	endfunction

	// Levels after a capture of s
	task automatic check_all(input logic [4:0] s);
		chk("strap_value", {27'h0, s}, {27'h0, strap_value});
		chk("strap_valid", 32'h1, {31'h0, strap_valid});
		chk("pad_func_en", 32'h1f, {27'h0, pad_func_en});
		chk("pulls", 32'h0, {22'h0, pull_up_en, pull_dn_en});
		chk("settings", status_of(s), {25'h0, 1'b1, sdio_output_rising, sdio_sample_rising,
			uart0_log_en, boot_reserved, boot_download, flash_supply_1v8});
	endtask

	// System reset with cause c while the host holds s on the pins
	task automatic sysrst(input logic [2:0] c, input logic [4:0] s);
		host_en <= 5'h1f;
		host_val <= s;
		reset_cause <= c;
		sys_rst_b <= 1'b0;
		repeat (5) @(posedge core_clk);
		sys_rst_b <= 1'b1;
		repeat (8) @(posedge core_clk);
		host_val <= 5'($random(seed));
		repeat (3) @(posedge core_clk);
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		stop_test();
	end

	initial begin
		seed = 60;
		errors = 0;
		samples_checked = 0;
		rst_b = 1'b0;
		sys_rst_b = 1'b0;
		reset_cause = 3'h1;
		host_en = 5'h00;
		host_val = 5'h00;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		repeat (12) @(posedge core_clk);
		chk("reset pulls", 32'h345, {22'h0, pull_up_en, pull_dn_en});
		chk("reset pads", 32'h0, {26'h0, strap_valid, pad_func_en});
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst_b <= 1'b1;
		repeat (10) @(posedge core_clk);
		check_all(5'h1a);
		// Every strap code, qualifying causes picked at random
		for (int i = 0; i < 32; i++) begin
			v = i[4:0];
			sysrst((($random(seed) & 3) == 0) ? 3'h4 : 3'($random(seed) | 1), v);
			check_all(v);
			apb(1'b0, 12'h000, 32'h0, 4'hf, {2'b10, 27'h0, v});
			apb(1'b0, 12'h008, 32'h0, 4'hf, {2'b10, status_of(v)});
			chk("held", {27'h0, v}, {27'h0, strap_value});
		end
		// Non-qualifying system reset keeps the straps
		sysrst(3'h0, ~v);
		check_all(v);
		// Firmware override of supply and SDIO timing
		apb(1'b1, 12'h004, {27'h0, ~v[4], ~v[3], 1'b1, ~v[0], 1'b1}, 4'h1, 34'h0);
		apb(1'b1, 12'h004, 32'h0, 4'h0, 34'h0);
		apb(1'b0, 12'h004, 32'h0, 4'hf, {2'b10, 27'h0, ~v[4], ~v[3], 1'b1, ~v[0], 1'b1});
		repeat (2) @(posedge core_clk);
		chk("override", {29'h0, ~v[0], ~v[3], ~v[4]},
			{29'h0, flash_supply_1v8, sdio_sample_rising, sdio_output_rising});
		chk("log kept", {31'h0, v[3]}, {31'h0, uart0_log_en});
		// Refused accesses
		apb(1'b1, 12'h000, 32'h1f, 4'hf, {2'b01, 32'h0});
		apb(1'b0, 12'h0fc, 32'h0, 4'hf, {2'b11, 32'h0});
		chk("ro strap", {27'h0, v}, {27'h0, strap_value});
		// System reset clears the override
		sysrst(3'h0, v);
		check_all(v);
		stop_test();
	end
endmodule

/* File: rtl/bsl_pkg.sv */
/*
 Shared constants and types of the boot strap latch: strap bit positions,
 pull defaults, register offsets, override and status fields.
 Assumes nothing of its surroundings; included by package name only.
*/
package bsl_pkg;

	// Strap vector layout
	localparam int STRAP_W        = 5;
	localparam int BIT_SUPPLY     = 0;
	localparam int BIT_BOOT_SEL   = 1;
	localparam int BIT_BOOT_QUAL  = 2;
	localparam int BIT_LOG_EDGE   = 3;
	localparam int BIT_OUT_EDGE   = 4;

	// Weak pull level of each pin: 1 pull-up, 0 pull-down
	localparam logic [4:0] STRAP_DEFAULT = 5'h1a;

	// Reset cause bits: power-on, slow watchdog, brownout
	localparam int         CAUSE_W         = 3;
	localparam logic [2:0] CAUSE_RECAPTURE = 3'h7;

	// Synchroniser depth
	localparam int SYNC_STAGES_DEF = 2;

	// APB register map
	localparam int          ADDR_W     = 12;
	localparam logic [11:0] OFF_STRAP  = 12'h000;
	localparam logic [11:0] OFF_OVR    = 12'h004;
	localparam logic [11:0] OFF_STATUS = 12'h008;

	// Override register fields
	localparam int         OVR_W          = 5;
	localparam int         OVR_SUPPLY_EN  = 0;
	localparam int         OVR_SUPPLY_VAL = 1;
	localparam int         OVR_SDIO_EN    = 2;
	localparam int         OVR_SAMPLE_VAL = 3;
	localparam int         OVR_OUTPUT_VAL = 4;
	localparam logic [4:0] OVR_RESET      = 5'h00;

	// Status register fields
	localparam int ST_W        = 7;
	localparam int ST_1V8      = 0;
	localparam int ST_DOWNLOAD = 1;
	localparam int ST_RESERVED = 2;
	localparam int ST_LOG      = 3;
	localparam int ST_SAMPLE   = 4;
	localparam int ST_OUTPUT   = 5;
	localparam int ST_VALID    = 6;

	typedef enum logic [1:0] {
		CAP_HOLD = 2'b01,
		CAP_RUN  = 2'b10
	} bsl_cap_state_t;

	typedef enum logic [2:0] {
		SEL_NONE   = 3'b000,
		SEL_STRAP  = 3'b001,
		SEL_OVR    = 3'b010,
		SEL_STATUS = 3'b100
	} bsl_reg_sel_t;

endpackage

/* File: rtl/bsl_strap_cap.sv */
/*
 Strap capture: follows the synchronised system reset and latches the
 strap pins at its release when the cause calls for a fresh capture.
 Assumes pins and reset level arrive through equal-depth synchronisers.
*/
`timescale 1ns/1ns
module bsl_strap_cap (
	input  wire logic                        core_clk,
	input  wire logic                        rst_b,
	input  wire logic                        sys_rst_act,
	input  wire logic [bsl_pkg::CAUSE_W-1:0] cause,
	input  wire logic [bsl_pkg::STRAP_W-1:0] pins,
	output logic      [bsl_pkg::STRAP_W-1:0] strap_r,
	output logic                             valid_r,
	output logic                             in_reset,
	output logic                             cap_fire
);

	bsl_pkg::bsl_cap_state_t state_r;
	bsl_pkg::bsl_cap_state_t state_nxt;

	// Release with a qualifying cause fires the capture
	always_comb begin
		state_nxt = state_r;
		cap_fire  = 1'b0;
		case (state_r)
			bsl_pkg::CAP_HOLD: begin
				if (!sys_rst_act) begin
					state_nxt = bsl_pkg::CAP_RUN;
					cap_fire  = |(cause & bsl_pkg::CAUSE_RECAPTURE); // [RULE1]
				end
			end
			bsl_pkg::CAP_RUN: begin
				if (sys_rst_act) begin
					state_nxt = bsl_pkg::CAP_HOLD;
				end
			end
			default: begin
				state_nxt = bsl_pkg::CAP_HOLD;
			end
		endcase
	end

	assign in_reset = (state_r == bsl_pkg::CAP_HOLD);

	// State register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= bsl_pkg::CAP_HOLD;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Strap latch, written only on a capture
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_r <= bsl_pkg::STRAP_DEFAULT;
			valid_r <= 1'b0;
		end else if (cap_fire) begin // [RULE2]
			strap_r <= pins; // [RULE1]
			valid_r <= 1'b1;
		end
	end

	a_strap_hold: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE2]
		!cap_fire |=> $stable(strap_r))
		else $error("strap bits changed without a capture");

	a_capture_value: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE1]
		$fell(sys_rst_act) && (|(cause & bsl_pkg::CAUSE_RECAPTURE)) && in_reset
		|=> strap_r == $past(pins) && valid_r)
		else $error("strap not latched at release");

endmodule

/* File: rtl/bsl_sync.sv */
/*
 Multi-bit level synchroniser, one flop chain per bit.
 Assumes each bit is a slow level; bits are not guaranteed coherent.
*/
`timescale 1ns/1ns
module bsl_sync #(
	parameter int               WIDTH   = 1,
	parameter int               STAGES  = 2,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	if (STAGES < 2) begin : g_bad
		$error("bsl_sync needs at least two stages");
	end

	// One chain per bit; only the last stage is read
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic [STAGES-1:0] chain_r;
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				chain_r <= {STAGES{RST_VAL[i]}};
			end else begin
				chain_r <= {chain_r[STAGES-2:0], d[i]};
			end
		end
		assign q[i] = chain_r[STAGES-1];
	end

endmodule

/* File: rtl/bsl_top.sv */
/*
 Boot strap latch with APB register access. Samples five strap pins at
 system reset release with a qualifying cause, holds them, and derives boot, supply, log and
 SDIO timing settings, with firmware override of supply and timing.
 Assumes rst_b is the power-domain reset, sys_rst_b and reset_cause come
 from the reset tree asynchronously, and the cause is stable around the
 release. APB runs on core_clk.
*/
// Implementation choices: the register offsets and the APB register port.
// Function
// RULE1: Latch five strap levels on qualifying reset release
// RULE2: Hold strap bits until power down
// RULE3: Software reads all five strap bits
// RULE4: Pins return to normal function after reset
// RULE5: Weak default pulls applied during reset
// RULE6: Board holds wanted levels through reset
// RULE7: Supply bit: 0 selects 3.3 V, 1 1.8 V
// RULE8: Select one flash; both zero download boot
// RULE9: Log bit enables boot log on uart0
// RULE10: Two bits set SDIO sample and output edges
// RULE11: Firmware may override supply and SDIO timing
// RULE12: Select zero, qualifier one: reserved, flash boot
`timescale 1ns/1ns
module bsl_top #(
	parameter int SYNC_STAGES = bsl_pkg::SYNC_STAGES_DEF
) (
	input  wire logic                        core_clk,
	input  wire logic                        rst_b,
	input  wire logic                        sys_rst_b,
	input  wire logic [bsl_pkg::CAUSE_W-1:0] reset_cause,
	input  wire logic [bsl_pkg::STRAP_W-1:0] strap_pin_in,
	output logic      [bsl_pkg::STRAP_W-1:0] pad_func_en,
	output logic      [bsl_pkg::STRAP_W-1:0] pull_up_en,
	output logic      [bsl_pkg::STRAP_W-1:0] pull_dn_en,
	output logic      [bsl_pkg::STRAP_W-1:0] strap_value,
	output logic                             strap_valid,
	output logic                             flash_supply_1v8,
	output logic                             boot_download,
	output logic                             boot_reserved,
	output logic                             uart0_log_en,
	output logic                             sdio_sample_rising,
	output logic                             sdio_output_rising,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [bsl_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	input  wire logic [3:0]                  pstrb,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr
);

	if (SYNC_STAGES < 2) begin : g_bad
		$error("bsl_top needs SYNC_STAGES of two or more");
	end

	localparam logic [bsl_pkg::CAUSE_W:0] RST_SYNC_INIT = '0;

	logic [bsl_pkg::STRAP_W-1:0] pins_s;
	logic [bsl_pkg::CAUSE_W:0]   rst_s;
	logic                        sys_rst_act;
	logic [bsl_pkg::STRAP_W-1:0] strap_r;
	logic                        valid_r;
	logic                        in_reset;
	logic                        cap_fire;
	logic [bsl_pkg::OVR_W-1:0]   ovr_r;
	logic [bsl_pkg::ST_W-1:0]    status_r;
	logic [bsl_pkg::ST_W-1:0]    status_nxt;
	logic [bsl_pkg::STRAP_W-1:0] pull_up_r;
	logic [bsl_pkg::STRAP_W-1:0] pull_dn_r;
	logic [bsl_pkg::STRAP_W-1:0] func_r;
	logic [31:0]                 prdata_r;
	logic                        err_r;
	logic                        setup;
	logic                        wr_take;
	bsl_pkg::bsl_reg_sel_t       sel_now;

	// Address decode shared by read and write paths
	function automatic bsl_pkg::bsl_reg_sel_t reg_sel(
		input logic [bsl_pkg::ADDR_W-1:0] addr
	);
		bsl_pkg::bsl_reg_sel_t s;
		if (addr == bsl_pkg::OFF_STRAP) begin
			s = bsl_pkg::SEL_STRAP;
		end else if (addr == bsl_pkg::OFF_OVR) begin
			s = bsl_pkg::SEL_OVR;
		end else if (addr == bsl_pkg::OFF_STATUS) begin
			s = bsl_pkg::SEL_STATUS;
		end else begin
			s = bsl_pkg::SEL_NONE;
		end
		return s;
	endfunction

	// Pins from the pads, defaults while rst_b is low
	bsl_sync #(
		.WIDTH   (bsl_pkg::STRAP_W),
		.STAGES  (SYNC_STAGES),
		.RST_VAL (bsl_pkg::STRAP_DEFAULT)
	) u_pin_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.d        (strap_pin_in),
		.q        (pins_s)
	);

	// Reset level and cause, same depth as the pins
	bsl_sync #(
		.WIDTH   (bsl_pkg::CAUSE_W + 1),
		.STAGES  (SYNC_STAGES),
		.RST_VAL (RST_SYNC_INIT)
	) u_rst_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.d        ({sys_rst_b, reset_cause}),
		.q        (rst_s)
	);

	assign sys_rst_act = !rst_s[bsl_pkg::CAUSE_W];

	// Capture engine
	bsl_strap_cap u_cap (
		.core_clk    (core_clk),
		.rst_b       (rst_b),
		.sys_rst_act (sys_rst_act),
		.cause       (rst_s[bsl_pkg::CAUSE_W-1:0]),
		.pins        (pins_s),
		.strap_r     (strap_r),
		.valid_r     (valid_r),
		.in_reset    (in_reset),
		.cap_fire    (cap_fire)
	);

	// Pulls on and pad function off while in reset
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pull_up_r <= bsl_pkg::STRAP_DEFAULT;
			pull_dn_r <= ~bsl_pkg::STRAP_DEFAULT;
			func_r    <= '0;
		end else if (sys_rst_act) begin
			pull_up_r <= bsl_pkg::STRAP_DEFAULT; // [RULE5]
			pull_dn_r <= ~bsl_pkg::STRAP_DEFAULT; // [RULE5]
			func_r    <= '0;
		end else begin
			pull_up_r <= '0;
			pull_dn_r <= '0;
			func_r    <= '1; // [RULE4]
		end
	end

	assign pull_up_en  = pull_up_r;
	assign pull_dn_en  = pull_dn_r;
	assign pad_func_en = func_r;
	assign strap_value = strap_r;
	assign strap_valid = valid_r;

	// Effective settings from straps and overrides
	always_comb begin
		status_nxt = '0;
		status_nxt[bsl_pkg::ST_1V8] = ovr_r[bsl_pkg::OVR_SUPPLY_EN] ?
			ovr_r[bsl_pkg::OVR_SUPPLY_VAL] : strap_r[bsl_pkg::BIT_SUPPLY]; // [RULE7] [RULE11]
		status_nxt[bsl_pkg::ST_DOWNLOAD] = !strap_r[bsl_pkg::BIT_BOOT_SEL] &&
			!strap_r[bsl_pkg::BIT_BOOT_QUAL]; // [RULE8]
		status_nxt[bsl_pkg::ST_RESERVED] = !strap_r[bsl_pkg::BIT_BOOT_SEL] &&
			strap_r[bsl_pkg::BIT_BOOT_QUAL]; // [RULE12]
		status_nxt[bsl_pkg::ST_LOG] = strap_r[bsl_pkg::BIT_LOG_EDGE]; // [RULE9]
		status_nxt[bsl_pkg::ST_SAMPLE] = ovr_r[bsl_pkg::OVR_SDIO_EN] ?
			ovr_r[bsl_pkg::OVR_SAMPLE_VAL] : strap_r[bsl_pkg::BIT_LOG_EDGE]; // [RULE10] [RULE11]
		status_nxt[bsl_pkg::ST_OUTPUT] = ovr_r[bsl_pkg::OVR_SDIO_EN] ?
			ovr_r[bsl_pkg::OVR_OUTPUT_VAL] : strap_r[bsl_pkg::BIT_OUT_EDGE]; // [RULE10] [RULE11]
		status_nxt[bsl_pkg::ST_VALID] = valid_r;
	end

	// Settings register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			status_r <= '0;
		end else begin
			status_r <= status_nxt;
		end
	end

	assign flash_supply_1v8   = status_r[bsl_pkg::ST_1V8];
	assign boot_download      = status_r[bsl_pkg::ST_DOWNLOAD];
	assign boot_reserved      = status_r[bsl_pkg::ST_RESERVED];
	assign uart0_log_en       = status_r[bsl_pkg::ST_LOG];
	assign sdio_sample_rising = status_r[bsl_pkg::ST_SAMPLE];
	assign sdio_output_rising = status_r[bsl_pkg::ST_OUTPUT];

	// APB phases
	assign setup   = psel && !penable;
	assign sel_now = reg_sel(paddr);
	assign wr_take = psel && penable && pwrite && pstrb[0] && !sys_rst_act &&
		(sel_now == bsl_pkg::SEL_OVR);
	assign pready  = 1'b1;
	assign prdata  = prdata_r;
	assign pslverr = psel && penable && err_r;

	// Override register, cleared while the system is held
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ovr_r <= bsl_pkg::OVR_RESET;
		end else if (sys_rst_act) begin
			ovr_r <= bsl_pkg::OVR_RESET;
		end else if (wr_take) begin
			ovr_r <= pwdata[bsl_pkg::OVR_W-1:0]; // [RULE11]
		end
	end

	// Read data and error loaded in the setup cycle
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_r <= '0;
			err_r    <= 1'b0;
		end else if (setup) begin
			prdata_r <= '0;
			err_r    <= 1'b0;
			if (sel_now == bsl_pkg::SEL_STRAP) begin
				prdata_r[bsl_pkg::STRAP_W-1:0] <= strap_r; // [RULE3]
				err_r <= pwrite;
			end else if (sel_now == bsl_pkg::SEL_OVR) begin
				prdata_r[bsl_pkg::OVR_W-1:0] <= ovr_r;
			end else if (sel_now == bsl_pkg::SEL_STATUS) begin
				prdata_r[bsl_pkg::ST_W-1:0] <= status_r;
				err_r <= pwrite;
			end else begin
				err_r <= 1'b1;
			end
		end
	end

	a_strap_readback: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE3]
		setup && !pwrite && sel_now == bsl_pkg::SEL_STRAP && !cap_fire
		##1 psel && penable |-> prdata[bsl_pkg::STRAP_W-1:0] == strap_value)
		else $error("strap read data wrong");

	a_pull_default: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE5]
		sys_rst_act && $past(sys_rst_act) |-> pull_up_en == bsl_pkg::STRAP_DEFAULT
		&& pull_dn_en == ~bsl_pkg::STRAP_DEFAULT && pad_func_en == '0)
		else $error("pulls wrong during reset");

	a_pad_release: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE4]
		$fell(sys_rst_act) |=> pad_func_en == '1 && pull_up_en == '0 && pull_dn_en == '0)
		else $error("pads not returned after release");

	// Settings follow the straps or overrides one cycle later
	a_supply_sel: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE7]
		!sys_rst_act && !ovr_r[bsl_pkg::OVR_SUPPLY_EN]
		|=> flash_supply_1v8 == $past(strap_value[bsl_pkg::BIT_SUPPLY]))
		else $error("supply select does not follow strap");

	a_boot_mode: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE8]
		!sys_rst_act |=> boot_download == (!$past(strap_value[bsl_pkg::BIT_BOOT_SEL]) &&
		!$past(strap_value[bsl_pkg::BIT_BOOT_QUAL])))
		else $error("boot mode decode wrong");

	a_boot_reserved: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE12]
		!sys_rst_act |=> boot_reserved == (!$past(strap_value[bsl_pkg::BIT_BOOT_SEL]) &&
		$past(strap_value[bsl_pkg::BIT_BOOT_QUAL])) && !(boot_reserved && boot_download))
		else $error("reserved combination not flash boot");

	a_log_enable: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE9]
		cap_fire ##1 1'b1 |=> uart0_log_en == strap_value[bsl_pkg::BIT_LOG_EDGE])
		else $error("log enable does not follow strap");

	a_sdio_timing: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE10]
		!sys_rst_act && !ovr_r[bsl_pkg::OVR_SDIO_EN] |=>
		sdio_sample_rising == $past(strap_value[bsl_pkg::BIT_LOG_EDGE]) &&
		sdio_output_rising == $past(strap_value[bsl_pkg::BIT_OUT_EDGE]))
		else $error("sdio edges do not follow strap");

	a_ovr_write: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE11]
		wr_take && pwdata[bsl_pkg::OVR_SUPPLY_EN] && !cap_fire ##1 !sys_rst_act
		|=> flash_supply_1v8 == $past(pwdata[bsl_pkg::OVR_SUPPLY_VAL], 2))
		else $error("supply override not applied");

	// Pads stay with the strap logic while held
	a_pads_held: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE4]
		in_reset |-> pad_func_en == '0)
		else $error("pads released while held");

	// Override cleared by system reset, ignored without byte strobe
	a_ovr_clear: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE11]
		sys_rst_act |=> ovr_r == bsl_pkg::OVR_RESET)
		else $error("override not cleared in system reset");

	a_strb_ignored: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE11]
		psel && penable && pwrite && !pstrb[0] && !sys_rst_act |=> ovr_r == $past(ovr_r))
		else $error("override written without strobe");

	// Refused accesses answer with an error
	a_ro_write_err: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE2]
		setup && pwrite && sel_now != bsl_pkg::SEL_OVR ##1 psel && penable |-> pslverr)
		else $error("read-only write not refused");

	a_unmapped_read: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE3]
		setup && !pwrite && sel_now == bsl_pkg::SEL_NONE ##1 psel && penable
		|-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");

endmodule
